// File: common/synth_cfg_pkg.sv
// Notes on behaviour
// RL1: Output power code bits 25:23 drive both outputs; 2.6 V supply allows codes 0, 1.
// RL2: External oscillator select enables external buffer and powers down internal oscillators.
// RL3: Software keeps swing code within supply limit and sets low-supply flag at 2.6 V.
// RL4: Feedback select 0 feeds oscillator direct; 1 feeds it through output-1 divider.
// RL5: Software matches pump supply range code to pump supply; code 11 unused.
// RL6: Gain compensation on at 0; at 1 pump current fixed by programmed code.
// RL7: Detector polarity 0 standard, 1 inverted; inverted only for inverting loops.
// RL8: Reference mode 01 differential, 10 crystal, 11 single-ended, 00 reserved.
// RL9: Unlock mute bit set turns both output stages off while unlocked.
// RL10: Lock indicator high when locked; lock flag invert bit inverts it.
// RL11: Lock window code selects 2 ns to 16 ns in 2 ns steps.
// RL12: Lock count code selects 4, 8, 16, 64, 256, 1024, 2048, 4096 comparisons.
// RL13: Each low-power bit at 1 puts its sub-block in low power.
// RL14: Software writes zero to every reserved and test-only bit.
// RL15: Tuning word bit 26 enables modulator output dithering.
// RL16: Modulator order 00 third, 01 second, 10 first, 11 fourth.
// RL17: Manual tuning 0 runs auto calibration; 1 uses manual fields, inhibits calibration.
// RL18: Manual core 00 high, 01/11 low, 10 mid; sub-band 0 to 31.
// RL19: Tuning word bit 12 enables temperature compensation during calibration.
// RL20: Precharge occupies code plus one calibration slots, one to four.
// RL21: Accuracy boost adds two calibration slots; defaults off.
// RL22: Calibration clock divides by 1 to 511; zero means 511.
// RL23: Output-1 divider 000 direct, 001-110 divide 2 to 64, 111 reserved.
// RL24: Status bit reads 1 while loop locked.
// RL25: Lock after count consecutive in-window comparisons; unlock on one miss.
package synth_cfg_pkg;
	localparam int REG_W      = 27;
	localparam int ADDR_W     = 4;
	localparam int FRAME_BITS = 32;
	localparam logic [3:0] LOCK_OUT_OFS  = 4'h4;
	localparam logic [3:0] LOW_POWER_OFS = 4'h5;
	localparam logic [3:0] TUNING_OFS    = 4'h6;
	localparam logic [3:0] STATUS_OFS    = 4'hA;
	localparam logic [26:0] LOCK_OUT_RST  = 27'h000_0000;
	localparam logic [26:0] LOW_POWER_RST = 27'h000_0000;
	localparam logic [26:0] TUNING_RST    = 27'h000_0000;
	// Lock and output word
	localparam int OUT_PWR_POS    = 23;
	localparam int LOW_SUPPLY_POS = 22;
	localparam int EXT_OSC_POS    = 19;
	localparam int SWING_POS      = 15;
	localparam int FB_SEL_POS     = 14;
	localparam int PUMP_RANGE_POS = 12;
	localparam int GAIN_OFF_POS   = 11;
	localparam int POLARITY_POS   = 10;
	localparam int REF_MODE_POS   = 8;
	localparam int MUTE_EN_POS    = 7;
	localparam int LOCK_INV_POS   = 6;
	localparam int WINDOW_POS     = 3;
	localparam int COUNT_POS      = 0;
	// Low-power word: defined bits only
	localparam logic [12:0] LOW_POWER_MASK = 13'h1FF5;
	// Tuning word
	localparam int DITHER_POS     = 26;
	localparam int SRC_OFF_POS    = 25;
	localparam int SINK_OFF_POS   = 24;
	localparam int MOD_ORDER_POS  = 22;
	localparam int MOD_CLK_POS    = 21;
	localparam int MANUAL_POS     = 20;
	localparam int CORE_POS       = 18;
	localparam int SUBBAND_POS    = 13;
	localparam int TEMP_COMP_POS  = 12;
	localparam int PRECHARGE_POS  = 10;
	localparam int BOOST_POS      = 9;
	localparam int CAL_DIV_POS    = 0;
	// Status word
	localparam int LOCKED_POS     = 7;
	// Lock detector, calibration and output-1 divider
	localparam logic [4:0] WINDOW_STEP_NS = 5'h02;
	localparam logic [8:0] CAL_DIV_MAX    = 9'h1FF;
	localparam logic [2:0] BOOST_SLOTS    = 3'h2;
	localparam logic [2:0] DIV_RESERVED   = 3'h7;

	typedef logic [12:0] lock_count_t;

	function automatic lock_count_t lock_target(input logic [2:0] code);
		unique case (code)
			3'h0: lock_target = 13'h0004;
			3'h1: lock_target = 13'h0008;
			3'h2: lock_target = 13'h0010;
			3'h3: lock_target = 13'h0040;
			3'h4: lock_target = 13'h0100;
			3'h5: lock_target = 13'h0400;
			3'h6: lock_target = 13'h0800;
			3'h7: lock_target = 13'h1000;
		endcase
	endfunction : lock_target
endpackage : synth_cfg_pkg

// File: common/lock_if.sv
`timescale 1ns/100ps
interface lock_if;
	logic [2:0] window_code;
	logic [2:0] count_code;
	logic       cmp_valid;
	logic [4:0] cmp_err_ns;
	logic       locked;

	modport detector (
		input  window_code,
		input  count_code,
		input  cmp_valid,
		input  cmp_err_ns,
		output locked
	);
	modport ctrl (
		output window_code,
		output count_code,
		output cmp_valid,
		output cmp_err_ns,
		input  locked
	);
endinterface : lock_if

// File: rtl/lock_detect.sv
`timescale 1ns/100ps
module lock_detect (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic nrst_i,
	// Detector side
	lock_if.detector  lk
);
	import synth_cfg_pkg::*;

	lock_count_t count_reg;
	logic        locked_reg;

	// RL11 window decode
	wire logic [4:0] window_ns = 5'((lk.window_code + 3'h1) * WINDOW_STEP_NS);
	wire logic       in_window = lk.cmp_err_ns <= window_ns;
	// RL12 count target
	wire lock_count_t target    = lock_target(lk.count_code);
	wire lock_count_t count_inc = count_reg + 13'h0001;

	// RL25 consecutive passes
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count_reg  <= 13'h0000;
			locked_reg <= 1'b0;
		end else if (lk.cmp_valid) begin
			if (!in_window) begin
				count_reg  <= 13'h0000;
				locked_reg <= 1'b0;
			end else if (!locked_reg) begin
				count_reg  <= count_inc;
				locked_reg <= count_inc >= target;
			end
		end
	end

	assign lk.locked = locked_reg;
endmodule : lock_detect

// File: rtl/cal_clock_div.sv
`timescale 1ns/100ps
module cal_clock_div (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	// Ratio and tick
	input  wire logic [8:0] ratio_i,
	output logic            tick_o
);
	import synth_cfg_pkg::*;

	logic [8:0] cnt_reg;

	// RL22 zero means maximum
	wire logic [8:0] ratio_eff = (ratio_i == 9'h000) ? CAL_DIV_MAX : ratio_i;
	wire logic       wrap      = cnt_reg >= ratio_eff - 9'h001;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_reg <= 9'h000;
			tick_o  <= 1'b0;
		end else begin
			cnt_reg <= wrap ? 9'h000 : cnt_reg + 9'h001;
			tick_o  <= wrap;
		end
	end
endmodule : cal_clock_div

// File: rtl/synth_lock_and_tuning_config.sv
`timescale 1ns/100ps
module synth_lock_and_tuning_config (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	// Serial control port
	input  wire logic       spi_clk_i,
	input  wire logic       spi_data_i,
	input  wire logic       spi_latch_i,
	output logic            spi_data_o,
	output logic            spi_data_oe_o,
	// Phase comparison results
	input  wire logic       cmp_valid_i,
	input  wire logic [4:0] cmp_err_ns_i,
	// Output-1 divider select from the divider word
	input  wire logic [2:0] out1_div_sel_i,
	// Calibrator handshake and results
	input  wire logic       cal_start_i,
	input  wire logic [1:0] cal_core_i,
	input  wire logic [4:0] cal_band_i,
	output logic            cal_busy_o,
	output logic            cal_precharge_o,
	output logic            cal_boost_o,
	output logic            cal_done_o,
	output logic            cal_temp_comp_o,
	output logic            cal_clk_tick_o,
	// Output stages
	output logic [2:0]      output_power_level_o,
	output logic            out_stage_en_o,
	output logic            lock_pin_o,
	// Oscillator
	output logic            external_oscillator_select_o,
	output logic            int_osc_en_o,
	output logic            osc_low_supply_flag_o,
	output logic [3:0]      osc_swing_level_o,
	output logic [1:0]      osc_core_o,
	output logic [4:0]      osc_subband_o,
	// Feedback path
	output logic            fb_divided_o,
	output logic [2:0]      fb_div_log2_o,
	// Pump and detector
	output logic [1:0]      pump_supply_range_o,
	output logic            gain_comp_en_o,
	output logic            detector_invert_o,
	output logic            pump_source_test_off_o,
	output logic            pump_sink_test_off_o,
	// Reference input
	output logic            ref_diff_en_o,
	output logic            ref_xtal_en_o,
	output logic            ref_single_en_o,
	// Low-power controls
	output logic [12:0]     low_power_o,
	// Modulator
	output logic            dither_en_o,
	output logic [2:0]      modulator_order_o,
	output logic            modulator_clock_test_off_o
);
	import synth_cfg_pkg::*;

	typedef enum logic [1:0] {
		CAL_IDLE,
		CAL_PRECHARGE,
		CAL_BOOST
	} cal_state_t;

	logic [26:0] lock_out_reg;
	logic [26:0] low_power_reg;
	logic [26:0] tuning_reg;

	// Serial port state
	logic        sclk_reg;
	logic        latch_reg;
	logic [31:0] shift_reg;
	logic [5:0]  bit_cnt_reg;
	logic [26:0] rd_shift_reg;
	logic        rd_active_reg;

	// Calibration state
	cal_state_t  cal_state_reg;
	cal_state_t  cal_state_next;
	logic [2:0]  slot_reg;
	logic [2:0]  slot_next;
	logic [1:0]  res_core_reg;
	logic [4:0]  res_band_reg;
	logic        done_reg;

	lock_if lk ();

	// Serial frame: read flag, 4 address bits, 27 data bits, MSB first
	wire logic       sclk_rise  = spi_clk_i & ~sclk_reg;
	wire logic       latch_rise = spi_latch_i & ~latch_reg;
	wire logic       frame_on   = ~spi_latch_i;
	wire logic       frame_full = bit_cnt_reg == 6'(FRAME_BITS);
	wire logic       is_read    = shift_reg[31];
	wire logic [3:0] wr_addr    = shift_reg[30:27];
	wire logic [26:0] wr_data   = shift_reg[26:0];
	wire logic       do_write   = latch_rise & frame_full & ~is_read;
	wire logic       wr_lock    = do_write & (wr_addr == LOCK_OUT_OFS);
	wire logic       wr_lp      = do_write & (wr_addr == LOW_POWER_OFS);
	wire logic       wr_tune    = do_write & (wr_addr == TUNING_OFS);
	wire logic       hdr_done   = sclk_rise & frame_on
		& (bit_cnt_reg == 6'(ADDR_W));
	wire logic       hdr_read   = shift_reg[ADDR_W-1];
	wire logic [3:0] rd_addr    = {shift_reg[2:0], spi_data_i};
	wire logic       locked     = lk.locked;

	// RL24 lock status readback
	wire logic [26:0] status_word = 27'(locked) << LOCKED_POS;
	logic [26:0] rd_word;
	always_comb begin
		unique case (rd_addr)
			LOCK_OUT_OFS:  rd_word = lock_out_reg;
			LOW_POWER_OFS: rd_word = low_power_reg;
			TUNING_OFS:    rd_word = tuning_reg;
			STATUS_OFS:    rd_word = status_word;
			default:       rd_word = 27'h000_0000;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sclk_reg  <= 1'b0;
			latch_reg <= 1'b1;
		end else begin
			sclk_reg  <= spi_clk_i;
			latch_reg <= spi_latch_i;
		end
	end

	// Bits past 33 are dropped; a 33rd bit takes the count to 33, so a long frame never commits
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shift_reg   <= 32'h0000_0000;
			bit_cnt_reg <= 6'h00;
		end else if (latch_rise) begin
			bit_cnt_reg <= 6'h00;
		end else if (sclk_rise & frame_on & (bit_cnt_reg < 6'h21)) begin
			shift_reg   <= {shift_reg[30:0], spi_data_i};
			bit_cnt_reg <= bit_cnt_reg + 6'h01;
		end
	end

	// Read data leaves on the edge that takes the last address bit
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_shift_reg  <= 27'h000_0000;
			rd_active_reg <= 1'b0;
		end else if (latch_rise) begin
			rd_active_reg <= 1'b0;
		end else if (hdr_done) begin
			rd_shift_reg  <= rd_word;
			rd_active_reg <= hdr_read;
		end else if (sclk_rise & frame_on & rd_active_reg) begin
			rd_shift_reg  <= {rd_shift_reg[25:0], 1'b0};
		end
	end

	assign spi_data_o    = rd_shift_reg[26];
	assign spi_data_oe_o = rd_active_reg & frame_on;

	// Reserved bits are stored as written; software keeps them zero
	// RL14 reserved bits stored
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lock_out_reg  <= LOCK_OUT_RST;
			low_power_reg <= LOW_POWER_RST;
			tuning_reg    <= TUNING_RST;
		end else begin
			if (wr_lock)
				lock_out_reg  <= wr_data;
			if (wr_lp)
				low_power_reg <= wr_data;
			if (wr_tune)
				tuning_reg    <= wr_data;
		end
	end

	// Lock detector
	assign lk.window_code = lock_out_reg[WINDOW_POS +: 3];
	assign lk.count_code  = lock_out_reg[COUNT_POS +: 3];
	assign lk.cmp_valid   = cmp_valid_i;
	assign lk.cmp_err_ns  = cmp_err_ns_i;

	lock_detect u_lock (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.lk     (lk.detector)
	);

	// RL1 output power
	assign output_power_level_o = lock_out_reg[OUT_PWR_POS +: 3];
	// RL9 mute on unlock
	assign out_stage_en_o = ~(lock_out_reg[MUTE_EN_POS] & ~locked);
	// RL10 lock pin polarity
	assign lock_pin_o = locked ^ lock_out_reg[LOCK_INV_POS];

	// RL2 oscillator source
	assign external_oscillator_select_o = lock_out_reg[EXT_OSC_POS];
	assign int_osc_en_o = ~lock_out_reg[EXT_OSC_POS];
	// RL3 supply-dependent settings passed through
	assign osc_low_supply_flag_o = lock_out_reg[LOW_SUPPLY_POS];
	assign osc_swing_level_o     = lock_out_reg[SWING_POS +: 4];

	// RL4 feedback path
	assign fb_divided_o = lock_out_reg[FB_SEL_POS];
	// RL23 reserved divider code runs direct
	wire logic [2:0] out1_log2 = (out1_div_sel_i == DIV_RESERVED)
		? 3'h0 : out1_div_sel_i;
	assign fb_div_log2_o = fb_divided_o ? out1_log2 : 3'h0;

	// RL5 pump supply range
	assign pump_supply_range_o = lock_out_reg[PUMP_RANGE_POS +: 2];
	// RL6 gain compensation
	assign gain_comp_en_o = ~lock_out_reg[GAIN_OFF_POS];
	// RL7 detector polarity
	assign detector_invert_o = lock_out_reg[POLARITY_POS];
	assign pump_source_test_off_o = tuning_reg[SRC_OFF_POS];
	assign pump_sink_test_off_o   = tuning_reg[SINK_OFF_POS];

	// RL8 reference mode; reserved code enables nothing
	wire logic [1:0] ref_mode = lock_out_reg[REF_MODE_POS +: 2];
	assign ref_diff_en_o   = ref_mode == 2'h1;
	assign ref_xtal_en_o   = ref_mode == 2'h2;
	assign ref_single_en_o = ref_mode == 2'h3;

	// RL13 low-power bits
	assign low_power_o = low_power_reg[12:0] & LOW_POWER_MASK;

	// RL15 dithering
	assign dither_en_o = tuning_reg[DITHER_POS];
	assign modulator_clock_test_off_o = tuning_reg[MOD_CLK_POS];
	// RL16 modulator order
	wire logic [1:0] order_code = tuning_reg[MOD_ORDER_POS +: 2];
	always_comb begin
		unique case (order_code)
			2'h0: modulator_order_o = 3'h3;
			2'h1: modulator_order_o = 3'h2;
			2'h2: modulator_order_o = 3'h1;
			2'h3: modulator_order_o = 3'h4;
		endcase
	end

	// RL17 manual or automatic tuning
	wire logic       manual    = tuning_reg[MANUAL_POS];
	// RL18 codes 01 and 11 both mean the low core
	wire logic [1:0] man_core  = tuning_reg[CORE_POS +: 2];
	wire logic [1:0] core_norm = (man_core == 2'h3) ? 2'h1 : man_core;
	assign osc_core_o    = manual ? core_norm : res_core_reg;
	assign osc_subband_o = manual ? tuning_reg[SUBBAND_POS +: 5]
		: res_band_reg;

	// RL19 temperature compensation
	assign cal_temp_comp_o = tuning_reg[TEMP_COMP_POS] & cal_busy_o;

	// RL22 calibration clock
	cal_clock_div u_cal_div (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.ratio_i (tuning_reg[CAL_DIV_POS +: 9]),
		.tick_o  (cal_clk_tick_o)
	);

	// RL20 precharge slot count
	wire logic [2:0] pre_slots = {1'b0, tuning_reg[PRECHARGE_POS +: 2]}
		+ 3'h1;
	// RL21 accuracy boost
	wire logic       boost_en  = tuning_reg[BOOST_POS];
	wire logic       slot_last_pre   = slot_reg == pre_slots - 3'h1;
	wire logic       slot_last_boost = slot_reg == BOOST_SLOTS - 3'h1;

	// RL17 start ignored while manual
	always_comb begin
		cal_state_next = cal_state_reg;
		slot_next      = slot_reg;
		unique case (cal_state_reg)
			CAL_IDLE: begin
				slot_next = 3'h0;
				if (cal_start_i & ~manual)
					cal_state_next = CAL_PRECHARGE;
			end
			CAL_PRECHARGE: begin
				if (cal_clk_tick_o) begin
					slot_next = slot_reg + 3'h1;
					if (slot_last_pre) begin
						slot_next      = 3'h0;
						cal_state_next = boost_en ? CAL_BOOST : CAL_IDLE;
					end
				end
			end
			CAL_BOOST: begin
				if (cal_clk_tick_o) begin
					slot_next = slot_reg + 3'h1;
					if (slot_last_boost) begin
						slot_next      = 3'h0;
						cal_state_next = CAL_IDLE;
					end
				end
			end
			default: begin
				slot_next      = 3'h0;
				cal_state_next = CAL_IDLE;
			end
		endcase
	end

	wire logic cal_finish = (cal_state_reg != CAL_IDLE)
		& (cal_state_next == CAL_IDLE);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cal_state_reg <= CAL_IDLE;
			slot_reg      <= 3'h0;
			done_reg      <= 1'b0;
		end else begin
			cal_state_reg <= cal_state_next;
			slot_reg      <= slot_next;
			done_reg      <= cal_finish;
		end
	end

	// Calibrator result is held so the selection stays stable
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			res_core_reg <= 2'h0;
			res_band_reg <= 5'h00;
		end else if (cal_finish) begin
			res_core_reg <= (cal_core_i == 2'h3) ? 2'h1 : cal_core_i;
			res_band_reg <= cal_band_i;
		end
	end

	assign cal_busy_o      = cal_state_reg != CAL_IDLE;
	assign cal_precharge_o = cal_state_reg == CAL_PRECHARGE;
	assign cal_boost_o     = cal_state_reg == CAL_BOOST;
	assign cal_done_o      = done_reg;
endmodule : synth_lock_and_tuning_config

// File: verification/cfg_monitor.sv
`timescale 1ns/100ps
module cfg_monitor (
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       nrst_i,
	// Watched ports
	input wire logic       cmp_valid_i,
	input wire logic [4:0] cmp_err_ns_i,
	input wire logic [2:0] out1_div_sel_i,
	input wire logic       cal_start_i,
	input wire logic       cal_busy_o,
	input wire logic       cal_precharge_o,
	input wire logic       cal_boost_o,
	input wire logic       cal_done_o,
	input wire logic       cal_temp_comp_o,
	input wire logic       lock_pin_o,
	input wire logic       fb_divided_o,
	input wire logic [2:0] fb_div_log2_o,
	input wire logic       external_oscillator_select_o,
	input wire logic       int_osc_en_o,
	input wire logic [2:0] modulator_order_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// Errors above 16 ns miss every window
	wire miss = cmp_valid_i && cmp_err_ns_i > 5'h10;

	osc_src_a: assert property (
		int_osc_en_o != external_oscillator_select_o)
		else $error("oscillator source clash");
	mod_order_a: assert property (
		modulator_order_o inside {[3'h1:3'h4]})
		else $error("modulator order out of range");
	fb_ratio_a: assert property (
		fb_div_log2_o == ((fb_divided_o && out1_div_sel_i != 3'h7)
		? out1_div_sel_i : 3'h0))
		else $error("feedback ratio wrong");
	no_relock_a: assert property (
		miss |=> ##1 $stable(lock_pin_o) [*3])
		else $error("lock regained too soon");
	cal_start_a: assert property (
		$rose(cal_busy_o) |-> $past(cal_start_i))
		else $error("calibration without request");
	cal_done_a: assert property (
		$fell(cal_busy_o) |-> cal_done_o ##1 !cal_done_o)
		else $error("done pulse wrong");
	cal_boost_a: assert property (
		$rose(cal_boost_o) |-> $past(cal_precharge_o) ##1 cal_boost_o)
		else $error("boost slots wrong");
	temp_comp_a: assert property (
		cal_temp_comp_o |-> cal_busy_o)
		else $error("compensation outside calibration");

	lock_c: cover property ($rose(lock_pin_o));
	boost_c: cover property ($rose(cal_boost_o));
	done_c: cover property (cal_done_o);
endmodule : cfg_monitor

bind synth_lock_and_tuning_config cfg_monitor u_cfg_monitor (
	.clk_i(clk_i), .nrst_i(nrst_i), .cmp_valid_i(cmp_valid_i),
	.cmp_err_ns_i(cmp_err_ns_i), .out1_div_sel_i(out1_div_sel_i),
	.cal_start_i(cal_start_i), .cal_busy_o(cal_busy_o),
	.cal_precharge_o(cal_precharge_o), .cal_boost_o(cal_boost_o),
	.cal_done_o(cal_done_o), .cal_temp_comp_o(cal_temp_comp_o),
	.lock_pin_o(lock_pin_o), .fb_divided_o(fb_divided_o),
	.fb_div_log2_o(fb_div_log2_o), .int_osc_en_o(int_osc_en_o),
	.external_oscillator_select_o(external_oscillator_select_o),
	.modulator_order_o(modulator_order_o)
);

// File: verification/host_model.sv
`timescale 1ns/100ps
module host_model (
	// Clock
	input  wire logic   clk_i,
	// Serial lines
	input  wire logic   sdo_i,
	output logic        sclk_o,
	output logic        sdi_o,
	output logic        latch_o,
	// Read results
	output logic        rd_valid_o,
	output logic [26:0] rd_word_o
);
	initial begin
		sclk_o = 1'b0;
		sdi_o = 1'b0;
		latch_o = 1'b1;
		rd_valid_o = 1'b0;
		rd_word_o = 27'h000_0000;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step

	// supplies at 5 V, reserved zero
	function automatic logic [26:0] legal(input logic [3:0] a,
		input logic [26:0] d);
		logic [26:0] v;
		v = d & ((a == 4'h4) ? 27'h38F_FFFF
			: (a == 4'h5) ? 27'h000_1FF5 : 27'h4DF_FFFF);
		if (a == 4'h4 && v[13:12] == 2'h3)
			v[13] = 1'b0;
		return v;
	endfunction : legal

	task automatic xfer(input logic rd, input logic [3:0] a,
		input logic [26:0] d);
		logic [31:0] f;
		logic [26:0] q;
		f = {rd, a, d};
		q = 27'h000_0000;
		latch_o = 1'b0;
		step(1);
		for (int i = 31; i >= 0; i--) begin
			// Read bit settled since the previous serial rise
			if (i < 27)
				q = {q[25:0], sdo_i};
			sdi_o = f[i];
			sclk_o = 1'b1;
			step(2);
			sclk_o = 1'b0;
			step(2);
		end
		latch_o = 1'b1;
		// Released line toggles so stale data never looks valid
		sdi_o = !sdi_o;
		step(3);
		rd_word_o = q;
		rd_valid_o = rd;
		step(1);
		rd_valid_o = 1'b0;
	endtask : xfer
endmodule : host_model

// File: verification/synth_lock_and_tuning_config_test.sv
`timescale 1ns/100ps
module synth_lock_and_tuning_config_test;
	import synth_cfg_pkg::*;
	logic        clk_i, nrst_i, sclk, sdi, latch, sdo, oe, cmp_v, start;
	logic        rd_v, busy, tick, tcomp, stage_en, lock_pin, ext_sel;
	logic        int_osc, gain_en, det_inv, r_diff, r_xtal, r_single, dith;
	logic        low_sup, fb_div, src_off, sink_off, clk_off;
	logic [3:0]  swing;
	logic [1:0]  cal_core, core, pump;
	logic [2:0]  div_sel, fb_log2, pwr, order;
	logic [4:0]  cmp_err, cal_band, band;
	logic [12:0] low_pwr;
	logic [26:0] rd_word;
	logic [26:0] exp_q[$];
	int          n_errors, num_checks, cyc;
	int          cnt_tab[8] = '{4, 8, 16, 64, 256, 1024, 2048, 4096};
	int          ord_tab[4] = '{3, 2, 1, 4};
	wire         sdo_line = oe ? sdo : 1'bz;

	always #2.5 clk_i = ~clk_i;

	host_model u_host_model (.clk_i(clk_i), .sdo_i(sdo_line),
		.sclk_o(sclk), .sdi_o(sdi), .latch_o(latch),
		.rd_valid_o(rd_v), .rd_word_o(rd_word));

	synth_lock_and_tuning_config u_synth_lock_and_tuning_config (
		.clk_i(clk_i), .nrst_i(nrst_i), .spi_clk_i(sclk),
		.spi_data_i(sdi), .spi_latch_i(latch), .spi_data_o(sdo),
		.spi_data_oe_o(oe), .cmp_valid_i(cmp_v), .cmp_err_ns_i(cmp_err),
		.out1_div_sel_i(div_sel), .cal_start_i(start),
		.cal_core_i(cal_core), .cal_band_i(cal_band), .cal_busy_o(busy),
		.cal_precharge_o(), .cal_boost_o(), .cal_done_o(),
		.cal_temp_comp_o(tcomp), .cal_clk_tick_o(tick),
		.output_power_level_o(pwr), .out_stage_en_o(stage_en),
		.lock_pin_o(lock_pin), .external_oscillator_select_o(ext_sel),
		.int_osc_en_o(int_osc), .osc_low_supply_flag_o(low_sup),
		.osc_swing_level_o(swing), .osc_core_o(core),
		.osc_subband_o(band), .fb_divided_o(fb_div),
		.fb_div_log2_o(fb_log2),
		.pump_supply_range_o(pump), .gain_comp_en_o(gain_en),
		.detector_invert_o(det_inv), .pump_source_test_off_o(src_off),
		.pump_sink_test_off_o(sink_off), .ref_diff_en_o(r_diff),
		.ref_xtal_en_o(r_xtal), .ref_single_en_o(r_single),
		.low_power_o(low_pwr), .dither_en_o(dith),
		.modulator_order_o(order), .modulator_clock_test_off_o(clk_off));

	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic rd(input logic [3:0] a, input logic [26:0] v);
		exp_q.push_back(v);
		u_host_model.xfer(1'b1, a, 27'h000_0000);
	endtask : rd

	task automatic pulse(input logic [4:0] e, input int n);
		cmp_err = e;
		cmp_v = 1'b1;
		step(n);
		cmp_v = 1'b0;
		step(2);
	endtask : pulse

	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	always @(posedge clk_i)
		if (rd_v)
			check(rd_word, exp_q.pop_front());

	// Generous ceiling: the sequence needs about 16k cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 40000) begin
			n_errors++;
			report_and_stop();
		end
	end

	initial begin
		logic [26:0] d;
		logic [31:0] got, exp;
		logic [2:0]  w;
		logic        inv, tc, bst;
		int          k, ticks;
		clk_i = 1'b0;
		nrst_i = 1'b0;
		{cmp_v, start, div_sel, cmp_err, cal_core, cal_band} = '0;
		void'($urandom(32'hdf31));
		step(2);
		nrst_i = 1'b1;
		check({stage_en, int_osc, order, lock_pin}, 6'h36);
		for (int a = 4; a < 7; a++)
			rd(4'(a), 27'h000_0000);
		for (int i = 0; i < 4; i++) begin
			d = u_host_model.legal(4'h4, 27'($urandom));
			d[9:8] = 2'(i);
			u_host_model.xfer(1'b0, 4'h4, d);
			rd(4'h4, d);
			got = {pwr, low_sup, ext_sel, int_osc, swing, fb_div, pump,
				gain_en, det_inv, r_diff, r_xtal, r_single};
			exp = {d[25:23], d[22], d[19], !d[19], d[18:15], d[14],
				d[13:12], !d[11], d[10], d[9:8] == 2'h1, d[9:8] == 2'h2,
				d[9:8] == 2'h3};
			check(got, exp);
			d = u_host_model.legal(4'h5, 27'($urandom));
			u_host_model.xfer(1'b0, 4'h5, d);
			rd(4'h5, d);
			check(32'(low_pwr), 32'(d[12:0]));
			d = u_host_model.legal(4'h6, 27'($urandom));
			d[23:22] = 2'(i);
			u_host_model.xfer(1'b0, 4'h6, d);
			rd(4'h6, d);
			check({dith, src_off, sink_off, clk_off, order},
				{d[26], d[25:24], d[21], 3'(ord_tab[i])});
		end
		// Unmapped address: write dropped, reads as zero
		u_host_model.xfer(1'b0, 4'h7, 27'h7FF_FFFF);
		rd(4'h7, 27'h000_0000);
		rd(4'h6, d);
		u_host_model.xfer(1'b0, 4'h4, 27'h000_4000);
		for (int s = 0; s < 8; s++) begin
			div_sel = 3'(s);
			step(1);
			check(fb_log2, (s == 7) ? 3'h0 : 3'(s));
		end
		for (int c = 0; c < 8; c++) begin
			// Last pass uses the widest window so its miss lies above all
			w = (c == 7) ? 3'h7 : 3'($urandom);
			inv = 1'($urandom);
			u_host_model.xfer(1'b0, 4'h4, {19'h0, 1'b1, inv, w, 3'(c)});
			pulse({w, 1'b0} + 5'h2, cnt_tab[c] - 1);
			check({lock_pin, stage_en}, {inv, 1'b0});
			pulse({w, 1'b0} + 5'h2, 1);
			check({lock_pin, stage_en}, {!inv, 1'b1});
			rd(4'hA, 27'h000_0080);
			pulse({w, 1'b0} + 5'h3, 1);
			check({lock_pin, stage_en}, {inv, 1'b0});
		end
		for (int p = 0; p < 4; p++) begin
			{tc, bst, cal_core, cal_band} = 9'($urandom);
			bst = p[0];
			d = {14'h0, tc, 2'(p), bst, 9'(p + 1)};
			u_host_model.xfer(1'b0, 4'h6, d);
			start = 1'b1;
			step(1);
			start = 1'b0;
			check({busy, tcomp}, {1'b1, tc});
			ticks = 0;
			for (k = 0; k < 500 && busy; k++) begin
				ticks += tick;
				step(1);
			end
			check(ticks, p + 1 + 2 * bst);
			exp = {(cal_core == 2'h3) ? 2'h1 : cal_core, cal_band};
			check({core, band}, exp);
		end
		d = {6'h0, 1'b1, 7'($urandom), 13'h0};
		u_host_model.xfer(1'b0, 4'h6, d);
		{cal_core, cal_band} = ~d[19:13];
		start = 1'b1;
		step(1);
		start = 1'b0;
		step(2);
		exp = {1'b0, (d[19:18] == 2'h3) ? 2'h1 : d[19:18], d[17:13]};
		check({busy, core, band}, exp);
		for (int r = 0; r < 2; r++) begin
			u_host_model.xfer(1'b0, 4'h6, 27'(r * 5));
			for (k = 0; k < 600 && !tick; k++)
				step(1);
			step(1);
			for (k = 1; k < 600 && !tick; k++)
				step(1);
			check(k, r ? 5 : 511);
		end
		step(5);
		report_and_stop();
	end
endmodule : synth_lock_and_tuning_config_test
